//--- rtl/rcb_pkg.sv
// Package for the recording control and bias register bank.
// Assumes a 250 MHz core clock and an SPI link clock from the host.
package rcb_pkg;

  // ==========================================================================
  // Register map, as paired byte addresses (low byte address given)
  // ==========================================================================
  localparam logic [6:0] ADDR_Y_BIAS = 7'h16;
  localparam logic [6:0] ADDR_Z_BIAS = 7'h18;
  localparam logic [6:0] ADDR_RECORDING_CONTROL = 7'h1A;
  localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h3E;

  // ==========================================================================
  // Reset values and field positions
  // ==========================================================================
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [15:0] RECORDING_CONTROL_RESET = 16'h1102;
  localparam logic [15:0] RECORDING_CONTROL_WMASK = 16'hBFFF;
  localparam logic [1:0] RATE_SEL_RESET = 2'h3;
  localparam int unsigned BIT_TIMEOUT = 15;
  localparam int unsigned BIT_PWRDN = 7;
  localparam int unsigned BIT_STATS = 6;
  localparam int unsigned BIT_VEL = 5;
  localparam int unsigned BIT_RSS = 4;
  localparam int unsigned BIT_AUTONULL = 0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TIMEOUT_MS = 30;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned AUTONULL_MS = 16;
  localparam int unsigned AUTONULL_CYCLES = AUTONULL_MS * 1000 * CLK_MHZ;
  localparam int unsigned AUTONULL_SAMPLES = 4096;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {MODE_MANUAL_SPECTRUM = 2'h0, MODE_AUTO_SPECTRUM = 2'h1,
                            MODE_TIME_CAPTURE = 2'h2, MODE_STREAMING = 2'h3} rcb_mode_t;
  typedef enum logic [1:0] {WIN_RECT = 2'h0, WIN_HANNING = 2'h1, WIN_FLATTOP = 2'h2,
                            WIN_NA = 2'h3} rcb_window_t;
  typedef enum logic [1:0] {STORE_NONE = 2'h0, STORE_ALARM = 2'h1, STORE_ALL = 2'h2,
                            STORE_RSVD = 2'h3} rcb_store_t;

  typedef struct packed {
    logic stream_timeout_en;
    logic unused14;
    rcb_window_t window;
    logic [3:0] rate_enable;
    logic power_down;
    logic statistics;
    logic velocity;
    logic rss;
    rcb_store_t storage;
    rcb_mode_t mode;
  } rcb_recording_control_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic write;
  } rcb_frame_t;

endpackage : rcb_pkg

//--- rtl/rcb_spi_link.sv
// SPI slave in the link clock domain and the register bank top in the core domain.
// Assumes SPI mode 3 and a frame of write bit, byte address and data byte.
//
// How it works
// - Each bias correction register holds a 16-bit twos complement offset.
// - The z bias register loads the autonull result and accepts host writes.
// - Recording control bits [1:0] select the operating mode.
// - Bits [13:12] select the window used before the FFT in spectrum modes.
// - Bits 8 to 11 enable rate options 0 to 3 individually.
// - Bit 7 powers down after each capture, outside streaming mode only.
// - Bit 6 enables statistics on time capture records.
// - Bit 5 selects velocity instead of acceleration in the user buffers.
// - Bit 4 puts the root-sum-square in the z buffers, outside streaming.
// - Bits [3:2] select the flash storage policy for records.
// - Storage code 01 stores records only when an alarm is exceeded.
// - Bit 15 halts streaming when no serial clock arrives for 30 ms.
// - Without the timeout, the streaming pin and the streaming mode code start and stop streaming.
// - Bias registers clear to zero at power-up.
// - The autonull command starts the datapath's bias estimate over 4096 samples.
// - Successive captures rotate through the enabled rate options in ascending order.
module rcb_spi_link
  import rcb_pkg::*;
(
  // Link side
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Link reset from the core clock domain
  input wire logic rst_n_i,
  // Read data from the core, held stable between frames
  input wire logic [15:0] rdata_i,
  // Finished frame towards the core
  output rcb_frame_t frame_o,
  output logic frame_toggle_o
);

  logic [15:0] shift_q;
  logic [3:0] count_q;
  logic [15:0] out_q;

  // ==========================================================================
  // Shift in on the rising edge; chip select clears the bit count.
  // ==========================================================================
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      count_q <= 4'h0;
      shift_q <= 16'h0000;
    end
    else
    begin
      shift_q <= {shift_q[14:0], mosi_i};
      count_q <= count_q + 4'h1;
    end
  end

  // Each full frame is published and announced by a toggle.
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_o <= '0;
      frame_toggle_o <= 1'b0;
    end
    else if (!cs_n_i && count_q == 4'hF)
    begin
      frame_o <= '{addr: shift_q[13:7], wdata: {8'h00, shift_q[6:0], mosi_i}, write: shift_q[14]};
      frame_toggle_o <= ~frame_toggle_o;
    end
  end

  // Read data shifts out on the falling edge, loaded at the frame start.
  always_ff @(negedge sclk_i)
  begin
    if (count_q == 4'h0)
      out_q <= rdata_i;
    else
      out_q <= {out_q[14:0], 1'b0};
  end

  assign miso_o = out_q[15];

endmodule // rcb_spi_link

// ==========================================================================
// Register bank top in the core clock domain
// ==========================================================================
module rcb_top
  import rcb_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Serial link from the host
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  // Streaming control pin
  input wire logic STREAM_PIN_I,
  // Datapath handshake on the core clock
  input wire logic CAPTURE_START_I,
  input wire logic NULL_DONE_I,
  input wire logic [15:0] NULL_Y_I,
  input wire logic [15:0] NULL_Z_I,
  output logic NULL_START_O,
  // Settings towards the datapath
  output logic [15:0] Y_BIAS_O,
  output logic [15:0] Z_BIAS_O,
  output rcb_recording_control_t RECORDING_CONTROL_O,
  output logic [1:0] RATE_SEL_O,
  output logic AUTO_PWRDN_O,
  output logic STATS_EN_O,
  output logic VELOCITY_O,
  output logic RSS_EN_O,
  output logic STREAM_ACTIVE_O,
  output logic STREAM_HALT_O
);

  localparam logic [22:0] TIMEOUT_LIMIT = 23'(TIMEOUT_CYCLES);

  logic link_rst_n_q;
  rcb_frame_t frame;
  logic frame_toggle;
  logic tog_meta_q;
  logic tog_sync_q;
  logic tog_seen_q;
  logic frame_stb;
  logic wr_y;
  logic wr_z;
  logic wr_rc;
  logic wr_cmd;
  logic [15:0] rdata_q;
  logic [15:0] y_bias_q;
  logic [15:0] z_bias_q;
  rcb_recording_control_t recording_control_q;
  rcb_recording_control_t active_q;
  logic [1:0] rate_sel_q;
  logic null_start_q;
  logic auto_pwrdn_q;
  logic stats_q;
  logic velocity_q;
  logic rss_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic sclk_meta_q;
  logic sclk_sync_q;
  logic sclk_prev_q;
  logic [22:0] idle_cnt_q;
  logic stream_halt_q;
  logic stream_active_q;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Replaces one byte of a register word, chosen by the byte address bit.
  function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic hi, input logic [7:0] b);
    merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  // True when a byte address falls on the register pair at base.
  function automatic logic hits(input logic [6:0] a, input logic [6:0] base);
    hits = (a[6:1] == base[6:1]);
  endfunction

  // Next enabled rate option after cur, ascending with wrap; cur if none is enabled.
  function automatic logic [1:0] next_rate(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] idx;
    next_rate = cur;
    for (int i = 4; i >= 1; i--)
    begin
      idx = cur + 2'(i);
      if (en[idx])
        next_rate = idx;
    end
  endfunction

  // ==========================================================================
  // Link and frame crossing
  // ==========================================================================
  rcb_spi_link rcb_spi_link_i (
    .sclk_i(SCLK_I),
    .cs_n_i(CS_N_I),
    .mosi_i(MOSI_I),
    .miso_o(MISO_O),
    .rst_n_i(link_rst_n_q),
    .rdata_i(rdata_q),
    .frame_o(frame),
    .frame_toggle_o(frame_toggle)
  );

  always_ff @(posedge CLOCK_I)
  begin
    link_rst_n_q <= RST_N_I;
  end

  // The frame word stays still for a whole frame after its toggle, so only the toggle is synchronised.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end
    else
    begin
      tog_meta_q <= frame_toggle;
      tog_sync_q <= tog_meta_q;
      tog_seen_q <= tog_sync_q;
    end
  end

  assign frame_stb = tog_sync_q ^ tog_seen_q;
  assign wr_y = frame_stb && frame.write && hits(frame.addr, ADDR_Y_BIAS);
  assign wr_z = frame_stb && frame.write && hits(frame.addr, ADDR_Z_BIAS);
  assign wr_rc = frame_stb && frame.write && hits(frame.addr, ADDR_RECORDING_CONTROL);
  assign wr_cmd = frame_stb && frame.write && hits(frame.addr, ADDR_GLOBAL_CMD) && !frame.addr[0];

  // ==========================================================================
  // Registers
  // ==========================================================================
  // A finished autonull wins over a host write in the same cycle.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      y_bias_q <= BIAS_RESET;
      z_bias_q <= BIAS_RESET;
    end
    else if (NULL_DONE_I)
    begin
      y_bias_q <= NULL_Y_I;
      z_bias_q <= NULL_Z_I;
    end
    else
    begin
      if (wr_y)
        y_bias_q <= merge_byte(y_bias_q, frame.addr[0], frame.wdata[7:0]);
      if (wr_z)
        z_bias_q <= merge_byte(z_bias_q, frame.addr[0], frame.wdata[7:0]);
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      recording_control_q <= rcb_recording_control_t'(RECORDING_CONTROL_RESET);
    else if (wr_rc)
      recording_control_q <= rcb_recording_control_t'(merge_byte(recording_control_q, frame.addr[0], frame.wdata[7:0]) & RECORDING_CONTROL_WMASK);
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      null_start_q <= 1'b0;
    else
      null_start_q <= wr_cmd && frame.wdata[BIT_AUTONULL];
  end

  // A read frame latches the word, which the link shifts out during the next frame.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      rdata_q <= 16'h0000;
    else if (frame_stb && !frame.write)
    begin
      case (frame.addr[6:1])
        ADDR_Y_BIAS[6:1]: rdata_q <= y_bias_q;
        ADDR_Z_BIAS[6:1]: rdata_q <= z_bias_q;
        ADDR_RECORDING_CONTROL[6:1]: rdata_q <= recording_control_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // Capture events
  // ==========================================================================
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      active_q <= rcb_recording_control_t'(RECORDING_CONTROL_RESET);
      rate_sel_q <= RATE_SEL_RESET;
    end
    else if (CAPTURE_START_I)
    begin
      active_q <= recording_control_q;
      rate_sel_q <= next_rate(rate_sel_q, recording_control_q.rate_enable);
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      auto_pwrdn_q <= 1'b0;
      stats_q <= 1'b0;
      velocity_q <= 1'b0;
      rss_q <= 1'b0;
    end
    else
    begin
      auto_pwrdn_q <= active_q.power_down && (active_q.mode != MODE_STREAMING);
      stats_q <= active_q.statistics && (active_q.mode == MODE_TIME_CAPTURE);
      velocity_q <= active_q.velocity;
      rss_q <= active_q.rss && (active_q.mode != MODE_STREAMING);
    end
  end

  // ==========================================================================
  // Streaming control and timeout
  // ==========================================================================
  always_ff @(posedge CLOCK_I)
  begin
    pin_meta_q <= STREAM_PIN_I;
    pin_sync_q <= pin_meta_q;
    sclk_meta_q <= SCLK_I;
    sclk_sync_q <= sclk_meta_q;
    sclk_prev_q <= sclk_sync_q;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I || (sclk_sync_q != sclk_prev_q) || !stream_active_q)
      idle_cnt_q <= 23'h000000;
    else if (idle_cnt_q != TIMEOUT_LIMIT)
      idle_cnt_q <= idle_cnt_q + 23'h000001;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I || !pin_sync_q)
      stream_halt_q <= 1'b0;
    else if (recording_control_q.stream_timeout_en && idle_cnt_q == TIMEOUT_LIMIT)
      stream_halt_q <= 1'b1;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      stream_active_q <= 1'b0;
    else
      stream_active_q <= pin_sync_q && (recording_control_q.mode == MODE_STREAMING) && !stream_halt_q;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign Y_BIAS_O = y_bias_q;
  assign Z_BIAS_O = z_bias_q;
  assign RECORDING_CONTROL_O = active_q;
  assign RATE_SEL_O = rate_sel_q;
  assign NULL_START_O = null_start_q;
  assign AUTO_PWRDN_O = auto_pwrdn_q;
  assign STATS_EN_O = stats_q;
  assign VELOCITY_O = velocity_q;
  assign RSS_EN_O = rss_q;
  assign STREAM_ACTIVE_O = stream_active_q;
  assign STREAM_HALT_O = stream_halt_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_null_pulse;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    null_start_q |=> !null_start_q;
  endproperty
  a_null_pulse: assert property (p_null_pulse) else $error("autonull start longer than one cycle");

  property p_unused_zero;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !recording_control_q.unused14;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused control bit set");

  property p_active_hold;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !CAPTURE_START_I |=> $stable(active_q);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active settings changed outside a capture start");

  property p_active_load;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    CAPTURE_START_I |=> active_q == $past(recording_control_q);
  endproperty
  a_active_load: assert property (p_active_load) else $error("capture start did not load the settings");

  property p_rate_enabled;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    CAPTURE_START_I && recording_control_q.rate_enable != 4'h0 |=> active_q.rate_enable[rate_sel_q];
  endproperty
  a_rate_enabled: assert property (p_rate_enabled) else $error("selected rate option is not enabled");

  property p_pwrdn_mode;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    auto_pwrdn_q |-> $past(active_q.mode) != MODE_STREAMING;
  endproperty
  a_pwrdn_mode: assert property (p_pwrdn_mode) else $error("power-down enabled in streaming mode");

  property p_halt_enable;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(stream_halt_q) |-> $past(recording_control_q.stream_timeout_en);
  endproperty
  a_halt_enable: assert property (p_halt_enable) else $error("streaming halted with timeout disabled");

  property p_idle_bound;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    idle_cnt_q <= TIMEOUT_LIMIT;
  endproperty
  a_idle_bound: assert property (p_idle_bound) else $error("idle counter beyond its limit");

endmodule // rcb_top

//--- sim/rcb_host_model.sv
// Host model: SPI master in mode 3, one 16-bit word per frame.
// Assumes the bench calls send between frames.
module rcb_host_model
(
  // Link side
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  // Word shifted in during the last frame
  output logic [15:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sclk_o, cs_n_o, mosi_o} = 3'b110;
  initial rx_o = 16'h0000;
  task automatic send(input logic [15:0] w);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      mosi_o = w[i];
      #3 sclk_o = 1'b1;
      rx_o = {rx_o[14:0], miso_i};
      #3;
    end
    // Chip select rises after every frame, which also clears the link bit count.
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule // rcb_host_model

//--- sim/recording_control_and_bias_regs_tb.sv
// Bench for the register bank: host frames in, register reads and settings out.
// Assumes a write flag, a 7-bit byte address and a data byte in each frame.
module recording_control_and_bias_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcb_pkg::*;
  logic CLOCK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic sclk, cs_n, mosi, miso, null_start, pwrdn, stats, vel, rss, s_active, s_halt;
  logic stream_pin = 1'b0, cap = 1'b0, null_done = 1'b0;
  logic [15:0] null_y = 16'h0000, null_z = 16'h0000, y_bias, z_bias, rx, v;
  rcb_recording_control_t recording_control;
  logic [1:0] rate_sel;
  int failures = 0, cmp_count = 0, cyc = 0, null_pulses = 0;
  int y_m, z_m, rc_m, act_m, rate_m;
  initial forever #2 CLOCK_I = ~CLOCK_I;
  rcb_host_model rcb_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .rx_o(rx));
  rcb_top rcb_top_i (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi),
    .MISO_O(miso), .STREAM_PIN_I(stream_pin), .CAPTURE_START_I(cap), .NULL_DONE_I(null_done),
    .NULL_Y_I(null_y), .NULL_Z_I(null_z), .NULL_START_O(null_start), .Y_BIAS_O(y_bias), .Z_BIAS_O(z_bias),
    .RECORDING_CONTROL_O(recording_control), .RATE_SEL_O(rate_sel), .AUTO_PWRDN_O(pwrdn), .STATS_EN_O(stats),
    .VELOCITY_O(vel), .RSS_EN_O(rss), .STREAM_ACTIVE_O(s_active), .STREAM_HALT_O(s_halt));
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("Compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic [15:0] w);
    rcb_host_model_i.send(w);
    repeat (8) @(posedge CLOCK_I);
    #1;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    xfer({1'b1, a[6:1], 1'b0, d[7:0]});
    xfer({1'b1, a[6:1], 1'b1, d[15:8]});
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    xfer({1'b0, a, 8'h00});
    xfer(16'h0000);
    d = rx;
  endtask
  task automatic reset_dut();
    RST_N_I = 1'b0;
    repeat (10) @(posedge CLOCK_I);
    #1 RST_N_I = 1'b1;
    y_m = 0;
    z_m = 0;
    rc_m = RECORDING_CONTROL_RESET;
    act_m = RECORDING_CONTROL_RESET;
    rate_m = RATE_SEL_RESET;
    null_pulses = 0;
    repeat (2) @(posedge CLOCK_I);
    #1;
  endtask
  task automatic check_regs();
    logic [15:0] d;
    rd(ADDR_Y_BIAS, d);
    check("y_bias_correction", d, 16'(y_m));
    rd(ADDR_Z_BIAS, d);
    check("z_bias_correction", d, 16'(z_m));
    rd(ADDR_RECORDING_CONTROL, d);
    check("recording_control", d, 16'(rc_m));
    check("y bias out", y_bias, 16'(y_m));
    check("z bias out", z_bias, 16'(z_m));
  endtask
  task automatic capture();
    int nxt;
    bit found;
    nxt = rate_m;
    found = 1'b0;
    for (int i = 1; i <= 4; i++)
      if (!found && rc_m[8 + ((rate_m + i) % 4)])
      begin
        nxt = (rate_m + i) % 4;
        found = 1'b1;
      end
    cap = 1'b1;
    @(posedge CLOCK_I);
    #1 cap = 1'b0;
    act_m = rc_m;
    rate_m = nxt;
    repeat (2) @(posedge CLOCK_I);
    #1;
    check("active control", recording_control, 16'(act_m));
    check("rate option", {14'h0000, rate_sel}, 16'(rate_m));
    check("mode", {14'h0000, recording_control.mode}, 16'(act_m & 3));
    check("window", {14'h0000, recording_control.window}, 16'((act_m >> 12) & 3));
    check("rate enables", {12'h000, recording_control.rate_enable}, 16'((act_m >> 8) & 15));
    check("storage", {14'h0000, recording_control.storage}, 16'((act_m >> 2) & 3));
    check("alarm storage", {15'h0000, recording_control.storage == STORE_ALARM}, 16'(((act_m >> 2) & 3) == 1));
    check("power down", {15'h0000, pwrdn}, 16'(act_m[7] && (act_m & 3) != 3));
    check("statistics", {15'h0000, stats}, 16'(act_m[6] && (act_m & 3) == 2));
    check("velocity", {15'h0000, vel}, 16'(act_m[5]));
    check("rss", {15'h0000, rss}, 16'(act_m[4] && (act_m & 3) != 3));
  endtask
  always @(posedge CLOCK_I)
  begin
    if (null_start === 1'b1)
      null_pulses++;
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(47319));
    reset_dut();
    check_regs();
    $display("Test reset done");
    for (int k = 0; k < 6; k++)
    begin
      v = $urandom;
      wr16(ADDR_Y_BIAS, v);
      y_m = v;
      v = $urandom;
      wr16(ADDR_Z_BIAS, v);
      z_m = v;
      v = $urandom;
      wr16(ADDR_RECORDING_CONTROL, v);
      rc_m = v & RECORDING_CONTROL_WMASK;
      check("held control", recording_control, 16'(act_m));
      check_regs();
      capture();
      $display("Test %0d done", k);
    end
    xfer({1'b1, ADDR_Z_BIAS[6:1], 1'b1, 8'hA5});
    z_m = (z_m & 'hFF) | ('hA5 << 8);
    check_regs();
    $display("Test byte write done");
    xfer({1'b1, ADDR_GLOBAL_CMD, 8'h01});
    check("autonull starts", 16'(null_pulses), 16'h0001);
    null_y = $urandom;
    null_z = $urandom;
    null_done = 1'b1;
    @(posedge CLOCK_I);
    #1 null_done = 1'b0;
    y_m = null_y;
    z_m = null_z;
    check_regs();
    $display("Test autonull done");
    wr16(ADDR_RECORDING_CONTROL, 16'h8003);
    rc_m = 16'h8003;
    stream_pin = 1'b1;
    repeat (6) @(posedge CLOCK_I);
    #1;
    check("stream on", {15'h0000, s_active}, 16'h0001);
    check("stream halt", {15'h0000, s_halt}, 16'h0000);
    stream_pin = 1'b0;
    repeat (6) @(posedge CLOCK_I);
    #1;
    check("stream off", {15'h0000, s_active}, 16'h0000);
    $display("Test streaming done");
    reset_dut();
    check_regs();
    capture();
    $display("Test second reset done");
    print_verdict();
  end
endmodule // recording_control_and_bias_regs_tb
